// File: logic/abs_consts.svh
/*
 * constants for the audio block status flag logic: register offsets,
 * field positions, reset values and fifo geometry.
 * assumes inclusion by bare name from logic/ files.
 */
`ifndef ABS_CONSTS_SVH
`define ABS_CONSTS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define ABS_OFS_STATUS      12'h000
`define ABS_OFS_MASK        12'h004
`define ABS_OFS_CLEAR       12'h008
`define ABS_OFS_CONTROL     12'h00C

// ****************************************************************
// field positions
// ****************************************************************
`define ABS_BIT_LATE        6
`define ABS_BIT_EARLY       5
`define ABS_BIT_CODEC       4
`define ABS_LVL_LSB         16
`define ABS_LVL_MSB         18
`define ABS_CTL_RX          0
`define ABS_CTL_SLAVE       1
`define ABS_CTL_PROT_LSB    2
`define ABS_CTL_PROT_MSB    3

// ****************************************************************
// reset values and geometry
// ****************************************************************
`define ABS_MASK_RESET      3'h0
`define ABS_CTL_RESET       4'h0
`define ABS_FIFO_DEPTH      9'h008
`define ABS_CNT_W           4

`endif

// File: logic/abs_pkg.sv
/*
 * types shared by the audio block status flag logic.
 * assumes abs_consts.svh for numeric values.
 */
package abs_pkg;

    // audio protocol selection
    typedef enum logic [1:0] {
        ABS_PROT_FREE  = 2'h0,
        ABS_PROT_SPDIF = 2'h1,
        ABS_PROT_AC97  = 2'h2
    } abs_prot_type;

    // fill level codes
    typedef enum logic [2:0] {
        ABS_LVL_EMPTY = 3'h0,
        ABS_LVL_Q1    = 3'h1,
        ABS_LVL_Q2    = 3'h2,
        ABS_LVL_Q3    = 3'h3,
        ABS_LVL_Q4    = 3'h4,
        ABS_LVL_FULL  = 3'h5
    } abs_lvl_type;

    // events from the rest of the audio block
    typedef struct packed {
        logic late_sync;
        logic early_sync;
        logic codec_wait;
    } abs_evt_type;

    // apb request
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } abs_apb_req_type;

endpackage

// File: logic/abs_level_enc.sv
/*
 * fifo fill level encoder for transmitter and receiver configurations.
 * assumes the fill count is synchronous and never above the depth.
 */
`timescale 1ns/1ps
`include "abs_consts.svh"

module abs_level_enc (
    // fill state
    input  wire logic [`ABS_CNT_W-1:0] fill_count,
    input  wire logic                  is_receiver,
    // encoded level
    output abs_pkg::abs_lvl_type       level_code
);

    // four times the count against multiples of the depth avoids division
    logic [8:0] scaled;
    assign scaled = {3'h0, fill_count, 2'h0};

    // receiver edges sit on the low side of each quarter, transmitter high
    always_comb begin
        if (fill_count == 4'h0) begin
            level_code = abs_pkg::ABS_LVL_EMPTY;
        end else if ({5'h00, fill_count} >= `ABS_FIFO_DEPTH) begin
            level_code = abs_pkg::ABS_LVL_FULL;
        end else if (is_receiver) begin
            if (scaled < `ABS_FIFO_DEPTH) begin
                level_code = abs_pkg::ABS_LVL_Q1;
            end else if (scaled < 9'(2 * `ABS_FIFO_DEPTH)) begin
                level_code = abs_pkg::ABS_LVL_Q2;
            end else if (scaled < 9'(3 * `ABS_FIFO_DEPTH)) begin
                level_code = abs_pkg::ABS_LVL_Q3;
            end else begin
                level_code = abs_pkg::ABS_LVL_Q4;
            end
        end else begin
            if (scaled <= `ABS_FIFO_DEPTH) begin
                level_code = abs_pkg::ABS_LVL_Q1;
            end else if (scaled <= 9'(2 * `ABS_FIFO_DEPTH)) begin
                level_code = abs_pkg::ABS_LVL_Q2;
            end else if (scaled <= 9'(3 * `ABS_FIFO_DEPTH)) begin
                level_code = abs_pkg::ABS_LVL_Q3;
            end else begin
                level_code = abs_pkg::ABS_LVL_Q4;
            end
        end
    end

endmodule

// File: logic/abs_status.sv
/*
 * status flag logic of one serial audio block with its apb register
 * slave: status, interrupt mask, flag clear and a small control word.
 * assumes event pulses and fill count come synchronous to sys_clk.
 */
// Overview of operation
// - three bit fill level in status bits 18:16, hardware only
// - transmitter level codes: empty, up to quarters inclusive, full
// - receiver level codes: empty, below quarter edges, full
// - late sync error flag at bit 6 when sync is missing
// - early sync error flag at bit 5 when sync comes early
// - sync error flags only set in slave mode
// - sync error flags unused under ac97 or spdif protocols
// - late sync interrupt only when its mask enable is set
// - late sync flag cleared by writing its clear bit
// - early sync interrupt gated by mask, flag cleared by clear bit
// - codec not ready flag at bit 4, one means not ready
// - codec flag used only with ac97 selected in receiver mode
// - codec interrupt gated by mask, flag cleared by clear bit
`timescale 1ns/1ps
`include "abs_consts.svh"

module abs_status (
    // clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    // apb slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [11:0]            paddr,
    input  wire logic [31:0]            pwdata,
    input  wire logic [3:0]             pstrb,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    // audio block events and fill state
    input  wire abs_pkg::abs_evt_type   events,
    input  wire logic [`ABS_CNT_W-1:0]  fill_count,
    // block interrupt and configuration out
    output logic                        block_irq,
    output logic                        is_slave,
    output logic                        is_receiver,
    output abs_pkg::abs_prot_type       protocol
);

    // ****************************************************************
    // bus decode
    // ****************************************************************

    // one-hot access states
    typedef enum logic [1:0] {
        ABS_BUS_IDLE = 2'b01,
        ABS_BUS_DONE = 2'b10
    } abs_bus_type;

    abs_bus_type bus_state;
    abs_bus_type next_bus_state;

    // address decode shared by read and write paths
    function automatic logic hit(input logic [11:0] addr, input logic [11:0] ofs);
        hit = (addr == ofs);
    endfunction

    logic access;
    logic wr_en;
    logic mapped;

    // access phase with a known offset; writes need the low byte lane
    assign access = psel && penable;
    assign mapped = hit(paddr, `ABS_OFS_STATUS) || hit(paddr, `ABS_OFS_MASK)
                 || hit(paddr, `ABS_OFS_CLEAR) || hit(paddr, `ABS_OFS_CONTROL);
    assign wr_en  = access && pwrite && mapped && pstrb[0];

    // zero wait states: ready in every access phase
    assign pready  = access;
    assign pslverr = access && !mapped;

    // bus state tracks completed accesses, for symmetry of setup/access
    always_comb begin
        unique case (bus_state)
            ABS_BUS_IDLE: next_bus_state = access ? ABS_BUS_DONE : ABS_BUS_IDLE;
            ABS_BUS_DONE: next_bus_state = ABS_BUS_IDLE;
            default:      next_bus_state = ABS_BUS_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bus_state <= ABS_BUS_IDLE;
        end else begin
            bus_state <= next_bus_state;
        end
    end

    // ****************************************************************
    // control and mask registers
    // ****************************************************************

    logic [2:0] irq_mask;   // late, early, codec enables
    logic [3:0] control;

    // mask writes
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_mask <= `ABS_MASK_RESET;
        end else if (wr_en && hit(paddr, `ABS_OFS_MASK)) begin
            irq_mask <= {pwdata[`ABS_BIT_LATE], pwdata[`ABS_BIT_EARLY],
                         pwdata[`ABS_BIT_CODEC]};
        end
    end

    // control writes
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            control <= `ABS_CTL_RESET;
        end else if (wr_en && hit(paddr, `ABS_OFS_CONTROL)) begin
            control <= pwdata[3:0];
        end
    end

    assign is_receiver = control[`ABS_CTL_RX];
    assign is_slave    = control[`ABS_CTL_SLAVE];
    assign protocol    = abs_pkg::abs_prot_type'(control[`ABS_CTL_PROT_MSB:`ABS_CTL_PROT_LSB]);

    // ****************************************************************
    // sticky flags
    // ****************************************************************

    logic late_flag;
    logic early_flag;
    logic codec_flag;
    logic sync_allowed;
    logic codec_allowed;
    logic clr_wr;

    assign sync_allowed  = is_slave && (protocol == abs_pkg::ABS_PROT_FREE);
    assign codec_allowed = (protocol == abs_pkg::ABS_PROT_AC97) && is_receiver;
    assign clr_wr        = wr_en && hit(paddr, `ABS_OFS_CLEAR);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            late_flag <= 1'b0;
        end else if (events.late_sync && sync_allowed) begin
            late_flag <= 1'b1;
        end else if (clr_wr && pwdata[`ABS_BIT_LATE]) begin
            late_flag <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            early_flag <= 1'b0;
        end else if (events.early_sync && sync_allowed) begin
            early_flag <= 1'b1;
        end else if (clr_wr && pwdata[`ABS_BIT_EARLY]) begin
            early_flag <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            codec_flag <= 1'b0;
        end else if (events.codec_wait && codec_allowed) begin
            codec_flag <= 1'b1;
        end else if (clr_wr && pwdata[`ABS_BIT_CODEC]) begin
            codec_flag <= 1'b0;
        end
    end

    // ****************************************************************
    // interrupt
    // ****************************************************************

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            block_irq <= 1'b0;
        end else begin
            block_irq <= (late_flag && irq_mask[2]) || (early_flag && irq_mask[1])
                      || (codec_flag && irq_mask[0]);
        end
    end

    // ****************************************************************
    // fill level and read data
    // ****************************************************************

    abs_pkg::abs_lvl_type level_code;

    abs_level_enc u_level (
        .fill_count  (fill_count),
        .is_receiver (is_receiver),
        .level_code  (level_code)
    );

    logic [31:0] status_word;

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`ABS_LVL_MSB:`ABS_LVL_LSB] = level_code;
        status_word[`ABS_BIT_LATE]  = late_flag;
        status_word[`ABS_BIT_EARLY] = early_flag;
        status_word[`ABS_BIT_CODEC] = codec_flag;
    end

    // read mux; clear register reads as zero
    always_comb begin
        prdata = 32'h0000_0000;
        if (access && !pwrite) begin
            if (hit(paddr, `ABS_OFS_STATUS)) begin
                prdata = status_word;
            end else if (hit(paddr, `ABS_OFS_MASK)) begin
                prdata[`ABS_BIT_LATE]  = irq_mask[2];
                prdata[`ABS_BIT_EARLY] = irq_mask[1];
                prdata[`ABS_BIT_CODEC] = irq_mask[0];
            end else if (hit(paddr, `ABS_OFS_CONTROL)) begin
                prdata[3:0] = control;
            end
        end
    end

endmodule

// File: tb/abs_status_asserts.sv
/* port checker for abs_status.
   assumes a bind from the bench top and the single sys_clk domain. */
`timescale 1ns/1ps
// ****************************************************************
// port checker
// ****************************************************************
module abs_status_checker (
    // clock and reset
    input wire logic                  sys_clk,
    input wire logic                  rst,
    // apb slave side
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [11:0]           paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [3:0]            pstrb,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    // events, fill and outputs
    input wire abs_pkg::abs_evt_type  events,
    input wire logic [3:0]            fill_count,
    input wire logic                  block_irq,
    input wire logic                  is_slave,
    input wire logic                  is_receiver,
    input wire abs_pkg::abs_prot_type protocol
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    logic       acc;
    logic       chg;
    logic       evt;
    logic [2:0] lvl;
    // helpers: access phase, mask or clear write, any event
    assign acc = psel && penable;
    assign chg = acc && pwrite && pstrb[0] && (paddr == 12'h004 || paddr == 12'h008);
    assign evt = |events;
    // expected level code, worked out by quarters of a depth of eight
    assign lvl = (fill_count == 4'h0) ? 3'h0 : (fill_count == 4'h8) ? 3'h5 :
                 is_receiver ? 3'(fill_count / 2 + 1) : 3'((fill_count + 1) / 2);
    sequence rd_at(logic [11:0] a);
        acc && !pwrite && paddr == a;
    endsequence
    sequence ctl_wr;
        acc && pwrite && pstrb[0] && paddr == 12'h00C;
    endsequence
    ready_follows_access_a: assert property (pready == acc)
        else $error("pready differs from access phase");
    idle_bus_quiet_a: assert property (!(acc && !pwrite) |-> prdata == 32'h0 && (acc || !pslverr))
        else $error("read data or error outside a read");
    unmapped_error_a: assert property (acc |-> pslverr == !(paddr inside {0, 4, 8, 12}))
        else $error("slave error wrong for address");
    status_layout_a: assert property (
        rd_at(12'h000) |-> prdata[18:16] == lvl && prdata[31:19] == 0 && prdata[15:7] == 0
            && prdata[3:0] == 0) else $error("status word wrong");
    clear_reads_zero_a: assert property (rd_at(12'h008) |-> prdata == 32'h0)
        else $error("clear register reads nonzero");
    control_view_a: assert property (
        ctl_wr |=> {protocol, is_slave, is_receiver} == $past(pwdata[3:0]))
        else $error("control view not updated");
    irq_rise_cause_a: assert property ($rose(block_irq) |-> $past(evt, 2) || $past(chg, 2))
        else $error("interrupt rose without cause");
    irq_fall_cause_a: assert property ($fell(block_irq) |-> $past(chg, 2))
        else $error("interrupt fell without clear or mask");
endmodule

// File: tb/abs_event_src.sv
/* far side model: frame-sync detector, codec link and fifo fill.
   assumes its tasks are called just after a rising sys_clk edge. */
`timescale 1ns/1ps
module abs_event_src (
    // clock
    input  wire logic           sys_clk,
    // toward the status block
    output abs_pkg::abs_evt_type events,
    output logic [3:0]          fill_count
);
    // quiet at time zero
    initial begin
        events = '0;
        fill_count = 4'h0;
    end
    // one-cycle pulse; a longer one would set the sticky flag again on the next edge
    task automatic pulse(input logic [2:0] which);
        events <= which;
        @(posedge sys_clk);
        events <= '0;
    endtask
    // fill level held until changed
    task automatic set_fill(input logic [3:0] n);
        fill_count <= n;
    endtask
endmodule

// File: tb/audio_block_status_flags_test.sv
/* bench for abs_status: apb master, event model and port checker.
   assumes the package, design, model and checker compile first. */
`timescale 1ns/1ps
`define CHK(nm, x, g) begin n_compared++; if ((g) !== (x)) begin n_errors++; \
    $display("mismatch %s expected %h seen %h", nm, x, g); end end
module audio_block_status_flags_test;
    // bench signals
    logic                  sys_clk, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [11:0]           paddr = '0;
    logic [31:0]           pwdata = '0, prdata, q;
    logic [3:0]            pstrb = 4'hF, fill_count;
    logic                  block_irq, is_slave, is_receiver, e;
    abs_pkg::abs_evt_type  events;
    abs_pkg::abs_prot_type protocol;
    int                    n_errors = 0, n_compared = 0;
    logic [2:0]            tx_lvl [9] = '{0, 1, 1, 2, 2, 3, 3, 4, 5};
    logic [2:0]            rx_lvl [9] = '{0, 1, 2, 2, 3, 3, 4, 4, 5};
    abs_status i_dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .events(events), .fill_count(fill_count),
        .block_irq(block_irq), .is_slave(is_slave), .is_receiver(is_receiver),
        .protocol(protocol));
    abs_event_src i_far (.sys_clk(sys_clk), .events(events), .fill_count(fill_count));
    // 4 ns clock
    initial begin
        sys_clk = 0;
        forever #2 sys_clk = ~sys_clk;
    end
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // one apb transfer; the pready wait is bounded
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            n_errors++;
            tally_and_finish();
        end
        q = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x, input string nm);
        apb(0, a, 32'h0);
        `CHK(nm, x, q)
    endtask
    task automatic test_regs;
        rd(12'h000, 32'h0, "status at reset");
        rd(12'h00C, 32'h0, "control at reset");
        // status is read only; software keeps its reserved bits at zero
        apb(1, 12'h000, 32'h0007_0070);
        rd(12'h000, 32'h0, "status after write");
        apb(1, 12'h004, 32'h70);
        rd(12'h008, 32'h0, "clear reads zero");
        pstrb <= 4'h0;
        apb(1, 12'h004, 32'h0);
        pstrb <= 4'hF;
        rd(12'h004, 32'h70, "mask kept without strobe");
        apb(1, 12'h004, 32'h0);
        apb(0, 12'h010, 32'h0);
        `CHK("unmapped error", 1'b1, e)
        $display("test_regs done");
    endtask
    task automatic test_level;
        for (int r = 0; r < 2; r++) begin
            apb(1, 12'h00C, 32'(r));
            for (int f = 0; f < 9; f++) begin
                i_far.set_fill(4'(f));
                rd(12'h000, {13'h0, r ? rx_lvl[f] : tx_lvl[f], 16'h0}, "level");
            end
        end
        i_far.set_fill(4'h0);
        $display("test_level done");
    endtask
    task automatic test_sync;
        apb(1, 12'h00C, 32'h2);
        i_far.pulse(3'b100);
        rd(12'h000, 32'h40, "late flag");
        `CHK("irq masked", 1'b0, block_irq)
        apb(1, 12'h004, 32'h40);
        i_far.pulse(3'b010);
        rd(12'h000, 32'h60, "both flags");
        `CHK("irq late", 1'b1, block_irq)
        apb(1, 12'h008, 32'h40);
        rd(12'h000, 32'h20, "late cleared");
        `CHK("irq early unmasked", 1'b0, block_irq)
        apb(1, 12'h004, 32'h20);
        rd(12'h000, 32'h20, "early held");
        `CHK("irq early", 1'b1, block_irq)
        apb(1, 12'h008, 32'h20);
        rd(12'h000, 32'h0, "early cleared");
        for (int i = 0; i < 4; i++) begin
            apb(1, 12'h00C, i == 0 ? 32'h0 : i == 1 ? 32'h6 : i == 2 ? 32'hA : 32'hE);
            i_far.pulse(3'b110);
            rd(12'h000, 32'h0, "sync gated");
        end
        $display("test_sync done");
    endtask
    task automatic test_codec;
        apb(1, 12'h004, 32'h10);
        for (int i = 0; i < 4; i++) begin
            apb(1, 12'h00C, i == 0 ? 32'h9 : i == 1 ? 32'h8 : i == 2 ? 32'h1 : 32'hD);
            i_far.pulse(3'b001);
            rd(12'h000, i == 0 ? 32'h10 : 32'h0, "codec flag");
            `CHK("codec irq", 1'(i == 0), block_irq)
            apb(1, 12'h008, 32'h10);
        end
        `CHK("codec irq cleared", 1'b0, block_irq)
        $display("test_codec done");
    endtask
    // event lands on the same edge as its clear, then a reset in mid-run
    task automatic test_reset;
        apb(1, 12'h00C, 32'h2);
        apb(1, 12'h004, 32'h40);
        fork
            apb(1, 12'h008, 32'h40);
            begin
                @(posedge sys_clk);
                i_far.pulse(3'b100);
            end
        join
        rd(12'h000, 32'h40, "set beats clear");
        `CHK("irq before reset", 1'b1, block_irq)
        rst <= 1;
        repeat (2) @(posedge sys_clk);
        rst <= 0;
        @(posedge sys_clk);
        `CHK("irq after reset", 1'b0, block_irq)
        rd(12'h004, 32'h0, "mask after reset");
        rd(12'h00C, 32'h0, "control after reset");
        rd(12'h000, 32'h0, "status after reset");
        $display("test_reset done");
    endtask
    // reset for twelve cycles, then the scenarios
    initial begin
        repeat (12) @(posedge sys_clk);
        rst <= 0;
        @(posedge sys_clk);
        test_regs();
        test_level();
        test_sync();
        test_codec();
        test_reset();
        tally_and_finish();
    end
endmodule
bind abs_status abs_status_checker i_chk (.sys_clk(sys_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .events(events),
    .fill_count(fill_count), .block_irq(block_irq), .is_slave(is_slave),
    .is_receiver(is_receiver), .protocol(protocol));
